// ### design/smc_top.sv
// Purpose: Serial module mode control and peripheral clock output
// Assumes: APB slave, one clock, sleep_i from same clock domain
// Notes: Every output registered
`include "smc_regs.svh"

module smc_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // System inputs
  input wire logic sleep_i,
  input wire logic sub_clk_i,
  input wire logic tmr_match_i,
  input wire logic [4:0] i2c_flags_i,
  // Peripheral clock output pin
  output logic clk_out_hi_o,
  output logic clk_out_lo_o,
  output logic clk_out_oe_o,
  // Interface control
  output smc_pkg::smc_role_t role_o,
  output logic lines_en_o,
  output logic spi_sck_o,
  output logic [7:0] spi_ctrl_o,
  output logic i2c_tx_dir_o,
  output logic i2c_tx_ack_o,
  output logic i2c_flag_clr_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  smc_pkg::smc_ctrl_t ctrl_ff, nxt_ctrl;
  smc_pkg::smc_state_t state_ff, nxt_state;
  smc_pkg::smc_role_t nxt_role;
  logic [7:0] spi_ctrl_ff, nxt_spi_ctrl;
  logic [1:0] i2c_ctrl_ff, nxt_i2c_ctrl;
  logic pready_ff, nxt_pready;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pslverr_ff, nxt_pslverr;
  logic acc_wr;
  logic hit_ctrl, hit_stat, hit_spi, hit_i2c, hit_any;
  logic [7:0] rd_byte;
  logic sub_s1_ff, sub_s2_ff, sub_s3_ff;
  logic sub_edge;
  logic [4:0] pre_ff, nxt_pre;
  logic [4:0] pre_half;
  logic sck_ff, nxt_sck;
  logic lines_en_ff, nxt_lines_en;
  logic flag_clr_ff, nxt_flag_clr;
  logic ck_on;
  logic ck_hi, ck_lo, ck_oe;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb begin
    hit_ctrl = (paddr_i == `SMC_OFF_CTRL);
    hit_stat = (paddr_i == `SMC_OFF_STAT);
    hit_spi = (paddr_i == `SMC_OFF_SPI);
    hit_i2c = (paddr_i == `SMC_OFF_I2C);
    hit_any = hit_ctrl | hit_stat | hit_spi | hit_i2c;
    acc_wr = psel_i & penable_i & pready_ff & pwrite_i;
  end

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctrl) begin
      rd_byte = {ctrl_ff[7:1], 1'b0};
    end else if (hit_stat) begin
      rd_byte = {5'h00, sleep_i, lines_en_ff, ck_oe};
    end else if (hit_spi) begin
      rd_byte = spi_ctrl_ff;
    end else if (hit_i2c) begin
      rd_byte = {i2c_flags_i, 1'b0, i2c_ctrl_ff};
    end
  end

  // ----------------------------------------
  // APB handshake, one wait state
  // ----------------------------------------
  always_comb begin
    nxt_pready = psel_i & penable_i & ~pready_ff;
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (nxt_pready) begin
      nxt_pslverr = ~hit_any;
      if (!pwrite_i) begin
        nxt_prdata = {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= nxt_pready;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_spi_ctrl = spi_ctrl_ff;
    nxt_i2c_ctrl = i2c_ctrl_ff;
    if (acc_wr && hit_ctrl) begin
      nxt_ctrl = pwdata_i[7:0] & `SMC_CTRL_WMASK;
    end
    if (acc_wr && hit_spi) begin
      nxt_spi_ctrl = pwdata_i[7:0];
    end
    if (acc_wr && hit_i2c) begin
      nxt_i2c_ctrl = pwdata_i[1:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= `SMC_CTRL_RST;
      spi_ctrl_ff <= `SMC_SPI_RST;
      i2c_ctrl_ff <= `SMC_I2C_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
      spi_ctrl_ff <= nxt_spi_ctrl;
      i2c_ctrl_ff <= nxt_i2c_ctrl;
    end
  end

  // ----------------------------------------
  // Operating state
  // ----------------------------------------
  always_comb begin
    nxt_state = smc_pkg::ST_OFF;
    if (ctrl_ff.mod_en) begin
      case (ctrl_ff.mode)
        `SMC_MODE_SPI_D4,
        `SMC_MODE_SPI_D16,
        `SMC_MODE_SPI_D64,
        `SMC_MODE_SPI_SUB,
        `SMC_MODE_SPI_TMR: begin
          nxt_state = smc_pkg::ST_SPI_M;
        end
        `SMC_MODE_SPI_SLV: begin
          nxt_state = smc_pkg::ST_SPI_S;
        end
        `SMC_MODE_I2C_SLV: begin
          nxt_state = smc_pkg::ST_I2C;
        end
        default: begin
          nxt_state = smc_pkg::ST_UNUSED;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Role, line enable and I2C flag clear
  // ----------------------------------------
  always_comb begin
    nxt_role = '0;
    nxt_lines_en = 1'b0;
    case (nxt_state)
      smc_pkg::ST_SPI_M: begin
        nxt_role.spi_master = 1'b1;
        nxt_lines_en = 1'b1;
      end
      smc_pkg::ST_SPI_S: begin
        nxt_role.spi_slave = 1'b1;
        nxt_lines_en = 1'b1;
      end
      smc_pkg::ST_I2C: begin
        nxt_role.i2c_slave = 1'b1;
        nxt_lines_en = 1'b1;
      end
      default: begin
        nxt_lines_en = 1'b0;
      end
    endcase
    nxt_flag_clr = (nxt_state == smc_pkg::ST_I2C) &&
                   (state_ff != smc_pkg::ST_I2C);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_ff <= smc_pkg::ST_OFF;
      role_o <= '0;
      lines_en_ff <= 1'b0;
      flag_clr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      role_o <= nxt_role;
      lines_en_ff <= nxt_lines_en;
      flag_clr_ff <= nxt_flag_clr;
    end
  end

  // ----------------------------------------
  // Sub clock synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sub_s1_ff <= 1'b0;
      sub_s2_ff <= 1'b0;
      sub_s3_ff <= 1'b0;
    end else begin
      sub_s1_ff <= sub_clk_i;
      sub_s2_ff <= sub_s1_ff;
      sub_s3_ff <= sub_s2_ff;
    end
  end

  // ----------------------------------------
  // SPI master clock generator
  // ----------------------------------------
  always_comb begin
    sub_edge = sub_s2_ff ^ sub_s3_ff;
    nxt_pre = 5'h00;
    nxt_sck = 1'b0;
    case (ctrl_ff.mode)
      `SMC_MODE_SPI_D16: pre_half = `SMC_SPI_HALF_D16;
      `SMC_MODE_SPI_D64: pre_half = `SMC_SPI_HALF_D64;
      default: pre_half = `SMC_SPI_HALF_D4;
    endcase
    if (state_ff == smc_pkg::ST_SPI_M) begin
      nxt_sck = sck_ff;
      case (ctrl_ff.mode)
        `SMC_MODE_SPI_SUB: begin
          if (sub_edge) begin
            nxt_sck = ~sck_ff;
          end
        end
        `SMC_MODE_SPI_TMR: begin
          if (tmr_match_i) begin
            nxt_sck = ~sck_ff;
          end
        end
        default: begin
          if (pre_ff >= pre_half) begin
            nxt_sck = ~sck_ff;
          end else begin
            nxt_pre = pre_ff + 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pre_ff <= 5'h00;
      sck_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      sck_ff <= nxt_sck;
    end
  end

  // ----------------------------------------
  // Peripheral clock output
  // ----------------------------------------
  always_comb begin
    ck_on = ctrl_ff.ck_en & ~sleep_i;
  end

  smc_clkout u_clkout (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .en_i(ck_on),
    .sel_i(ctrl_ff.ck_sel),
    .tmr_match_i(tmr_match_i),
    .pin_hi_o(ck_hi),
    .pin_lo_o(ck_lo),
    .pin_oe_o(ck_oe)
  );

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  always_comb begin
    prdata_o = prdata_ff;
    pready_o = pready_ff;
    pslverr_o = pslverr_ff;
    clk_out_hi_o = ck_hi;
    clk_out_lo_o = ck_lo;
    clk_out_oe_o = ck_oe;
    lines_en_o = lines_en_ff;
    spi_sck_o = sck_ff;
    spi_ctrl_o = spi_ctrl_ff;
    i2c_tx_dir_o = i2c_ctrl_ff[1];
    i2c_tx_ack_o = i2c_ctrl_ff[0];
    i2c_flag_clr_o = flag_clr_ff;
  end

endmodule : smc_top

// ### design/smc_regs.svh
// Purpose: Register map and constants of the serial module control
// Assumes: APB word offsets, byte addresses
// Notes: Definitions only
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define SMC_OFF_CTRL 8'h00
`define SMC_OFF_STAT 8'h04
`define SMC_OFF_SPI 8'h08
`define SMC_OFF_I2C 8'h0C

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define SMC_CTRL_RST 8'hE0
`define SMC_CTRL_WMASK 8'hFE
`define SMC_SPI_RST 8'h00
`define SMC_I2C_RST 2'h0

// ----------------------------------------
// Mode field codes
// ----------------------------------------
`define SMC_MODE_SPI_D4 3'h0
`define SMC_MODE_SPI_D16 3'h1
`define SMC_MODE_SPI_D64 3'h2
`define SMC_MODE_SPI_SUB 3'h3
`define SMC_MODE_SPI_TMR 3'h4
`define SMC_MODE_SPI_SLV 3'h5
`define SMC_MODE_I2C_SLV 3'h6

// ----------------------------------------
// Clock output select codes
// ----------------------------------------
`define SMC_CKSEL_SYS 2'h0
`define SMC_CKSEL_D4 2'h1
`define SMC_CKSEL_D8 2'h2
`define SMC_CKSEL_TMR 2'h3

// ----------------------------------------
// Half period counts minus one
// ----------------------------------------
`define SMC_CK_HALF_D4 2'h1
`define SMC_CK_HALF_D8 2'h3
`define SMC_SPI_HALF_D4 5'h01
`define SMC_SPI_HALF_D16 5'h07
`define SMC_SPI_HALF_D64 5'h1F

`endif

// ### design/smc_pkg.sv
// Purpose: Types of the serial module control
// Assumes: Constants live in smc_regs.svh
// Notes: Nothing is imported by users
package smc_pkg;

  // ----------------------------------------
  // Control register layout
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] mode;
    logic ck_en;
    logic [1:0] ck_sel;
    logic mod_en;
    logic rsvd;
  } smc_ctrl_t;

  // ----------------------------------------
  // Role flags driven to the interface logic
  // ----------------------------------------
  typedef struct packed {
    logic spi_master;
    logic spi_slave;
    logic i2c_slave;
  } smc_role_t;

  // ----------------------------------------
  // Module operating state
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_OFF,
    ST_SPI_M,
    ST_SPI_S,
    ST_I2C,
    ST_UNUSED
  } smc_state_t;

endpackage : smc_pkg

// ### design/smc_clkout.sv
// Purpose: Peripheral clock output generator
// Assumes: Pad merges hi/lo half-cycle levels (DDR output)
// Notes: Starts and stops only on whole pulses
`include "smc_regs.svh"

module smc_clkout (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Control
  input wire logic en_i,
  input wire logic [1:0] sel_i,
  input wire logic tmr_match_i,
  // Pin
  output logic pin_hi_o,
  output logic pin_lo_o,
  output logic pin_oe_o
);

  logic run_ff, nxt_run;
  logic lvl_ff, nxt_lvl;
  logic [1:0] hc_ff, nxt_hc;
  logic [1:0] half;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_run = run_ff;
    nxt_lvl = lvl_ff;
    nxt_hc = hc_ff;
    half = (sel_i == `SMC_CKSEL_D8) ? `SMC_CK_HALF_D8 : `SMC_CK_HALF_D4;
    case (sel_i)
      `SMC_CKSEL_SYS: begin
        nxt_run = en_i;
        nxt_lvl = en_i;
        nxt_hc = 2'h0;
      end
      `SMC_CKSEL_TMR: begin
        if (tmr_match_i) begin
          if (run_ff && lvl_ff) begin
            nxt_lvl = 1'b0;
          end else begin
            nxt_run = en_i;
            nxt_lvl = en_i;
          end
        end
      end
      default: begin
        if (!run_ff || hc_ff == half) begin
          nxt_hc = 2'h0;
          if (run_ff && lvl_ff) begin
            nxt_lvl = 1'b0;
          end else begin
            nxt_run = en_i;
            nxt_lvl = en_i;
          end
        end else begin
          nxt_hc = hc_ff + 2'h1;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Registers, pin levels straight from flops
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      run_ff <= 1'b0;
      lvl_ff <= 1'b0;
      hc_ff <= 2'h0;
      pin_hi_o <= 1'b0;
      pin_lo_o <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      lvl_ff <= nxt_lvl;
      hc_ff <= nxt_hc;
      pin_hi_o <= nxt_lvl;
      pin_lo_o <= nxt_lvl & (sel_i != `SMC_CKSEL_SYS);
      pin_oe_o <= nxt_run;
    end
  end

endmodule : smc_clkout

// ### dv/smc_top_asserts.sv
// Purpose: Port assertions of smc_top
// Assumes: One clock domain
// Notes: Bound to every smc_top instance
module smc_top_asserts (
  // Clock, reset and inputs
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic sleep_i,
  // Outputs
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic clk_out_hi_o,
  input wire logic clk_out_lo_o,
  input wire logic clk_out_oe_o,
  input wire smc_pkg::smc_role_t role_o,
  input wire logic lines_en_o,
  input wire logic i2c_flag_clr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // ----
  // Sequences, property and assertions
  // ----
  sequence s_ctrl_read;
    pready_o && !pwrite_i && paddr_i == 8'h00;
  endsequence
  sequence s_clr_pulse;
    role_o.i2c_slave ##1 !i2c_flag_clr_o;
  endsequence
  property p_stop_whole;
    $fell(clk_out_oe_o) |-> !$past(clk_out_lo_o);
  endproperty
  AST_BIT0_ZERO: assert property (s_ctrl_read |-> prdata_o[0] == 1'b0)
    else $error("ctrl bit0 read as one");
  AST_ROLE_ONEHOT: assert property ($onehot0(role_o))
    else $error("role not one-hot");
  AST_ROLE_LINES: assert property (role_o != 3'b000 |-> lines_en_o)
    else $error("role active with lines floating");
  AST_CLR_I2C: assert property (i2c_flag_clr_o |-> s_clr_pulse)
    else $error("flag clear outside i2c entry");
  AST_PIN_SYNC: assert property (clk_out_lo_o |-> clk_out_hi_o)
    else $error("pin rose inside a cycle");
  AST_OFF_STEADY: assert property (!clk_out_oe_o |-> !clk_out_hi_o && !clk_out_lo_o)
    else $error("pin moves while off");
  AST_STOP_WHOLE: assert property (p_stop_whole)
    else $error("clock output cut in high phase");
  AST_START_HIGH: assert property ($rose(clk_out_oe_o) |-> clk_out_hi_o)
    else $error("clock output starts low");
  AST_SLEEP_OFF: assert property (sleep_i && !clk_out_oe_o |=> !clk_out_oe_o)
    else $error("clock output restarts in sleep");
endmodule : smc_top_asserts

bind smc_top smc_top_asserts smc_top_asserts_i (
  .clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .sleep_i(sleep_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .clk_out_hi_o(clk_out_hi_o),
  .clk_out_lo_o(clk_out_lo_o),
  .clk_out_oe_o(clk_out_oe_o),
  .role_o(role_o),
  .lines_en_o(lines_en_o),
  .i2c_flag_clr_o(i2c_flag_clr_o)
);

// ### dv/smc_pck_sink.sv
// Purpose: External logic clocked from the clock output pin
// Assumes: Pin shows hi then lo within each system cycle
// Notes: Undriven pin reads low
module smc_pck_sink (
  // Clock
  input wire logic clk_sys_i,
  // Pin
  input wire logic pin_hi_i,
  input wire logic pin_lo_i,
  input wire logic pin_oe_i,
  // Count of rising pin edges
  output int rises_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_lo = 1'b0;
  initial rises_o = 0;
  // Rise when a high half follows a low half
  always @(posedge clk_sys_i) begin
    if (pin_oe_i && pin_hi_i && !last_lo) rises_o <= rises_o + 1;
    last_lo <= pin_oe_i && pin_lo_i;
  end
endmodule : smc_pck_sink

// ### dv/serial_module_mode_and_clock_out_tb.sv
// Purpose: Self-checking bench of smc_top
// Assumes: One-wait APB slave, byte registers
// Notes: Integer register model checked at every read except the sleep status read
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin num_errors++; $display("BAD %s exp %0h got %0h", n, e, s); end end

module serial_module_mode_and_clock_out_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic sleep_i = 1'b0;
  logic sub_clk_i = 1'b0;
  logic tmr_match_i = 1'b0;
  logic [4:0] i2c_flags_i = 5'h00;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, clk_out_hi_o, clk_out_lo_o, clk_out_oe_o;
  smc_pkg::smc_role_t role_o;
  logic lines_en_o, spi_sck_o, i2c_tx_dir_o, i2c_tx_ack_o, i2c_flag_clr_o;
  logic [7:0] spi_ctrl_o;
  logic sck_q = 1'b0;
  logic perr;
  int num_errors = 0, cmp_count = 0, cyc = 0, clr_seen = 0, rises;
  int m_ctrl = 32'hE0, m_spi = 0, m_i2c = 0;
  int sck_t[$];
  int pd[5] = '{4, 16, 64, 14, 10};
  int cd[4] = '{1, 4, 8, 10};

  smc_top smc_top_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .sleep_i(sleep_i),
    .sub_clk_i(sub_clk_i), .tmr_match_i(tmr_match_i),
    .i2c_flags_i(i2c_flags_i), .clk_out_hi_o(clk_out_hi_o),
    .clk_out_lo_o(clk_out_lo_o), .clk_out_oe_o(clk_out_oe_o),
    .role_o(role_o), .lines_en_o(lines_en_o), .spi_sck_o(spi_sck_o),
    .spi_ctrl_o(spi_ctrl_o), .i2c_tx_dir_o(i2c_tx_dir_o),
    .i2c_tx_ack_o(i2c_tx_ack_o), .i2c_flag_clr_o(i2c_flag_clr_o));
  smc_pck_sink smc_pck_sink_i (.clk_sys_i(clk_sys_i),
    .pin_hi_i(clk_out_hi_o), .pin_lo_i(clk_out_lo_o),
    .pin_oe_i(clk_out_oe_o), .rises_o(rises));

  always #10 clk_sys_i = ~clk_sys_i;
  // ----
  // Timer match, sub clock and event logging
  // ----
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    tmr_match_i <= (cyc % 5 == 4);
    if (cyc % 7 == 6) sub_clk_i <= ~sub_clk_i;
    if (spi_sck_o === 1'b1 && sck_q === 1'b0) sck_t.push_back(cyc);
    sck_q <= spi_sck_o;
    if (i2c_flag_clr_o === 1'b1) clr_seen <= clr_seen + 1;
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      report_and_stop();
    end
    r = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, {8'h5A, 16'h0, d}, r);
    if (a == 8'h00) m_ctrl = d & 8'hFE;
    if (a == 8'h08) m_spi = d;
    if (a == 8'h0C) m_i2c = d[1:0];
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic [31:0] r;
    logic [31:0] e;
    e = (a == 8'h00) ? m_ctrl : (a == 8'h08) ? m_spi : 32'h0;
    if (a == 8'h0C) e = {i2c_flags_i, 1'b0, m_i2c[1:0]};
    apb(1'b0, a, 32'h0, r);
    `CHK("rdata", e, r)
    `CHK("slverr", a > 8'h0C, perr)
  endtask : rd

  function automatic logic [7:0] cv(input int m, k, s, e);
    return {m[2:0], k[0], s[1:0], e[0], 1'b1};
  endfunction : cv

  initial begin
    logic [31:0] r;
    logic [2:0] er;
    int p0;
    r = $urandom(32'hDF13);
    i2c_flags_i <= 5'($urandom);
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    foreach (cd[i]) rd(8'(4 * i));
    rd(8'h10);
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      wr(8'h00, cv(m, 0, 0, 1));
      sck_t.delete();
      repeat (200) @(posedge clk_sys_i);
      er = (m < 5) ? 3'b100 : (m == 5) ? 3'b010 : (m == 6) ? 3'b001 : 3'b000;
      `CHK("role", er, role_o)
      if (m < 7) `CHK("lines", 1'b1, lines_en_o)
      if (m > 4) `CHK("sck_idle", 1'b0, spi_sck_o)
      if (m < 5) `CHK("sck_per", pd[m], sck_t[2] - sck_t[1])
      rd(8'h00);
    end
    `CHK("clr_once", 1, clr_seen)
    $display("test modes done");
    wr(8'h08, 8'($urandom));
    wr(8'h00, cv(0, 0, 0, 0));
    repeat (3) @(posedge clk_sys_i);
    `CHK("off_lines", 1'b0, lines_en_o)
    `CHK("off_role", 3'b000, role_o)
    wr(8'h00, cv(0, 0, 0, 1));
    rd(8'h08);
    `CHK("spi_out", m_spi[7:0], spi_ctrl_o)
    wr(8'h0C, 8'($urandom));
    wr(8'h00, cv(6, 0, 0, 0));
    p0 = clr_seen;
    wr(8'h00, cv(6, 0, 0, 1));
    repeat (3) @(posedge clk_sys_i);
    `CHK("flag_clr", p0 + 1, clr_seen)
    `CHK("tx_dir", m_i2c[1], i2c_tx_dir_o)
    `CHK("tx_ack", m_i2c[0], i2c_tx_ack_o)
    rd(8'h0C);
    $display("test enable done");
    foreach (cd[s]) begin
      wr(8'h00, cv(7, 1, s, 0));
      repeat (10) @(posedge clk_sys_i);
      p0 = rises;
      repeat (80) @(posedge clk_sys_i);
      `CHK("ck_rises", 80 / cd[s], rises - p0)
    end
    wr(8'h00, cv(7, 0, 1, 0));
    repeat (12) @(posedge clk_sys_i);
    `CHK("ck_off", 1'b0, clk_out_oe_o)
    wr(8'h00, cv(7, 1, 1, 0));
    sleep_i <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    `CHK("ck_sleep", 1'b0, clk_out_oe_o)
    apb(1'b0, 8'h04, 32'h0, r);
    `CHK("st_sleep", 1'b1, r[2])
    sleep_i <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    `CHK("ck_wake", 1'b1, clk_out_oe_o)
    $display("test clock out done");
    report_and_stop();
  end
endmodule : serial_module_mode_and_clock_out_tb
